// ---- design/rtcdsa_top.v ----
// summer-time adjust block: two rule registers on apb, calendar compare, hour nudges
// assumes the clock counters arrive on this clock in the format set by the control bits
//
// Operation
// - enabled and spring rule matching: pulse an extra hour increment.
// - enabled and autumn rule reached: suppress the next hour increment.
// - after autumn fires, stay disarmed until the hour leaves, then re-arm.
// - spring word: meridiem 31, hour 30:24, week 18:16, weekday 10:8, month 7:0.
// - autumn word uses the same layout.
// - meridiem compared with hours bit 7 only if twelve-hour at write.
// - hour compared with hours bits 6:0, interpreted with write-time modes.
// - week of month maintained; 1 to 4 ordinal, 5 means last week.
// - weekday field compared with weekday counter bits 2:0.
// - month field compared with the month counter.
// - rule registers writable as whole words or single bytes.
// - hour and month converted on write; later format changes leave them.
// - forward skip means alarms inside the skipped hour never fire.
// - backward repeat means alarms inside the repeated hour fire twice.
// - logic acts only while the block enable bit is set.
// - soft reset bit clears both rules and self-clears one clock later.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

`include "rtcdsa_defs.vh"

module rtcdsa_top
(
	input  wire        clock,
	input  wire        reset_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [7:0]  cur_hours,
	input  wire [7:0]  cur_weekday,
	input  wire [7:0]  cur_month,
	input  wire [7:0]  cur_day,
	input  wire [7:0]  cur_month_days,
	input  wire        hour_carry,
	output reg         hour_advance,
	output reg         hour_inhibit,
	output reg         block_enable,
	output reg         summer_time_enable,
	output reg         binary_format_select,
	output reg         twelve_hour_mode
);

	// ****************************************************************
	// state codes of the backward rule
	// ****************************************************************
	localparam [1:0] AUT_ARMED = 2'b00;
	localparam [1:0] AUT_HOLD  = 2'b01;
	localparam [1:0] AUT_SPENT = 2'b10;
	localparam [4:0] CTRL_RESET = `RTCDSA_CTRL_RESET;

	// ****************************************************************
	// format helpers
	// ****************************************************************
	function [7:0] bcd2bin;
		input [7:0] v;
		begin
			bcd2bin = {1'b0, v[7:4], 3'b000} + {3'b000, v[7:4], 1'b0} + {4'h0, v[3:0]};
		end
	endfunction

	function [7:0] to_bin;
		input [7:0] v;
		input       is_bin;
		begin
			if (is_bin)
				to_bin = v;
			else
				to_bin = bcd2bin(v);
		end
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg         soft_reset;
	reg  [1:0]  aut_state;
	reg  [1:0]  next_aut_state;
	reg         spring_match_q;
	reg         autumn_match_q;
	reg  [31:0] wconv;
	reg  [7:0]  hour_wr;
	reg  [31:0] next_prdata;
	reg         next_pslverr;
	reg  [7:0]  hour_bin;
	reg  [7:0]  month_bin;
	reg  [7:0]  day_bin;
	reg  [7:0]  len_bin;
	reg  [2:0]  week_num;
	reg         is_last;
	reg         spring_match;
	reg         autumn_match;
	wire        clear;
	wire        run;
	wire        apb_wr;
	wire        sel_spring;
	wire        sel_autumn;
	wire        sel_ctrl;
	wire [31:0] spring_rule;
	wire [31:0] autumn_rule;
	wire        spring_twelve;
	wire        autumn_twelve;

	// soft reset acts like the block reset for one clock
	assign clear      = !reset_n || soft_reset;
	assign run        = block_enable && summer_time_enable;
	assign apb_wr     = psel && penable && pready && pwrite;
	assign sel_spring = (paddr == `RTCDSA_OFF_SPRING);
	assign sel_autumn = (paddr == `RTCDSA_OFF_AUTUMN);
	assign sel_ctrl   = (paddr == `RTCDSA_OFF_CTRL);

	// ****************************************************************
	// write-time conversion of rule data
	// ****************************************************************
	always @*
	begin
		hour_wr = to_bin({1'b0, pwdata[`RTCDSA_HOUR_HI:`RTCDSA_HOUR_LO]},
		                 binary_format_select);
		wconv = pwdata & `RTCDSA_RULE_MASK;
		// hour and month stored binary, so later format flips do not disturb them
		wconv[`RTCDSA_HOUR_HI:`RTCDSA_HOUR_LO] = hour_wr[6:0];
		wconv[`RTCDSA_MONTH_HI:`RTCDSA_MONTH_LO] =
			to_bin(pwdata[`RTCDSA_MONTH_HI:`RTCDSA_MONTH_LO],
			       binary_format_select);
	end

	rtcdsa_rule_store u_store
	(
		.clock         (clock),
		.clear         (clear),
		.wr_spring     (apb_wr && sel_spring),
		.wr_autumn     (apb_wr && sel_autumn),
		.strb          (pstrb),
		.wdata         (wconv),
		.twelve_in     (twelve_hour_mode),
		.spring_rule   (spring_rule),
		.autumn_rule   (autumn_rule),
		.spring_twelve (spring_twelve),
		.autumn_twelve (autumn_twelve)
	);

	// ****************************************************************
	// calendar view and rule compare
	// ****************************************************************
	always @*
	begin
		hour_bin  = to_bin({1'b0, cur_hours[6:0]}, binary_format_select);
		month_bin = to_bin(cur_month, binary_format_select);
		day_bin   = to_bin(cur_day, binary_format_select);
		len_bin   = to_bin(cur_month_days, binary_format_select);
		// ordinal week; days past the 28th get week 0, so they match only the last-week code or a week code of 0
		if (day_bin <= 8'h07)
			week_num = 3'h1;
		else if (day_bin <= 8'h0e)
			week_num = 3'h2;
		else if (day_bin <= 8'h15)
			week_num = 3'h3;
		else if (day_bin <= 8'h1c)
			week_num = 3'h4;
		else
			week_num = 3'h0;
		is_last = ({1'b0, day_bin} + {1'b0, `RTCDSA_WEEK_DAYS}) > {1'b0, len_bin};

		// no wildcards: software must keep every field valid
		spring_match =
			(spring_rule[`RTCDSA_HOUR_HI:`RTCDSA_HOUR_LO] == hour_bin[6:0]) &&
			(!spring_twelve || (spring_rule[`RTCDSA_MERID_BIT] == cur_hours[7])) &&
			((spring_rule[`RTCDSA_WEEK_HI:`RTCDSA_WEEK_LO] == `RTCDSA_WEEK_LAST) ?
			 is_last : (spring_rule[`RTCDSA_WEEK_HI:`RTCDSA_WEEK_LO] == week_num)) &&
			(spring_rule[`RTCDSA_WDAY_HI:`RTCDSA_WDAY_LO] == cur_weekday[2:0]) &&
			(spring_rule[`RTCDSA_MONTH_HI:`RTCDSA_MONTH_LO] == month_bin);

		autumn_match =
			(autumn_rule[`RTCDSA_HOUR_HI:`RTCDSA_HOUR_LO] == hour_bin[6:0]) &&
			(!autumn_twelve || (autumn_rule[`RTCDSA_MERID_BIT] == cur_hours[7])) &&
			((autumn_rule[`RTCDSA_WEEK_HI:`RTCDSA_WEEK_LO] == `RTCDSA_WEEK_LAST) ?
			 is_last : (autumn_rule[`RTCDSA_WEEK_HI:`RTCDSA_WEEK_LO] == week_num)) &&
			(autumn_rule[`RTCDSA_WDAY_HI:`RTCDSA_WDAY_LO] == cur_weekday[2:0]) &&
			(autumn_rule[`RTCDSA_MONTH_HI:`RTCDSA_MONTH_LO] == month_bin);
	end

	// ****************************************************************
	// forward rule
	// ****************************************************************
	always @(posedge clock)
	begin
		if (clear)
		begin
			spring_match_q <= 1'b0;
			hour_advance   <= 1'b0;
		end
		else
		begin
			spring_match_q <= spring_match;
			// one pulse on entering the hour; the skipped hour carries no alarm
			hour_advance   <= run && spring_match && !spring_match_q;
		end
	end

	// ****************************************************************
	// backward rule
	// ****************************************************************
	always @*
	begin
		next_aut_state = aut_state;
		case (aut_state)
			AUT_ARMED:
				if (run && autumn_match && !autumn_match_q)
					next_aut_state = AUT_HOLD;
			AUT_HOLD:
				if (!run)
					next_aut_state = AUT_ARMED;
				else if (hour_carry)
					next_aut_state = AUT_SPENT;
			AUT_SPENT:
				// hour value repeats after the eaten carry, so wait for it to leave
				if (!autumn_match)
					next_aut_state = AUT_ARMED;
			default:
				next_aut_state = AUT_ARMED;
		endcase
	end

	always @(posedge clock)
	begin
		if (clear)
		begin
			aut_state      <= AUT_ARMED;
			autumn_match_q <= 1'b0;
			hour_inhibit   <= 1'b0;
		end
		else
		begin
			aut_state      <= next_aut_state;
			autumn_match_q <= autumn_match;
			hour_inhibit   <= (next_aut_state == AUT_HOLD);
		end
	end

	// ****************************************************************
	// control register
	// ****************************************************************
	always @(posedge clock)
	begin
		if (!reset_n)
			soft_reset <= 1'b0;
		else
			soft_reset <= apb_wr && sel_ctrl && pstrb[0] && pwdata[`RTCDSA_CTL_SRST];
	end

	always @(posedge clock)
	begin
		if (clear)
		begin
			block_enable         <= CTRL_RESET[`RTCDSA_CTL_ENABLE];
			summer_time_enable   <= CTRL_RESET[`RTCDSA_CTL_STE];
			binary_format_select <= CTRL_RESET[`RTCDSA_CTL_BIN];
			twelve_hour_mode     <= CTRL_RESET[`RTCDSA_CTL_H12];
		end
		else if (apb_wr && sel_ctrl && pstrb[0] && !pwdata[`RTCDSA_CTL_SRST])
		begin
			// rules may be loaded before the enable bit is set
			block_enable         <= pwdata[`RTCDSA_CTL_ENABLE];
			summer_time_enable   <= pwdata[`RTCDSA_CTL_STE];
			binary_format_select <= pwdata[`RTCDSA_CTL_BIN];
			twelve_hour_mode     <= pwdata[`RTCDSA_CTL_H12];
		end
	end

	// ****************************************************************
	// apb slave, zero wait states
	// ****************************************************************
	always @*
	begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (sel_spring)
			next_prdata = spring_rule & `RTCDSA_RULE_MASK;
		else if (sel_autumn)
			next_prdata = autumn_rule & `RTCDSA_RULE_MASK;
		else if (sel_ctrl)
			next_prdata = {17'h00000, hour_inhibit, is_last, week_num, aut_state,
			               3'h0, twelve_hour_mode, binary_format_select,
			               summer_time_enable, soft_reset, block_enable};
		else
			next_pslverr = 1'b1;
	end

	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && !penable;
			if (psel && !penable)
			begin
				pslverr <= next_pslverr;
				prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
			end
			else
			begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
			end
		end
	end

endmodule

`default_nettype wire

// ---- common/rtcdsa_defs.vh ----
// register map, field layout, reset values and codes of the summer-time adjust block
// assumes inclusion inside a module body or at file level before the modules
`ifndef RTCDSA_DEFS_VH
`define RTCDSA_DEFS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define RTCDSA_OFF_SPRING   8'h18
`define RTCDSA_OFF_AUTUMN   8'h1c
`define RTCDSA_OFF_CTRL     8'h20

// ****************************************************************
// rule word layout
// ****************************************************************
`define RTCDSA_MERID_BIT    31
`define RTCDSA_HOUR_HI      30
`define RTCDSA_HOUR_LO      24
`define RTCDSA_WEEK_HI      18
`define RTCDSA_WEEK_LO      16
`define RTCDSA_WDAY_HI      10
`define RTCDSA_WDAY_LO      8
`define RTCDSA_MONTH_HI     7
`define RTCDSA_MONTH_LO     0
`define RTCDSA_RULE_MASK    32'hff07_07ff
`define RTCDSA_RULE_RESET   32'h0000_0000

// ****************************************************************
// control register bits
// ****************************************************************
`define RTCDSA_CTL_ENABLE   0
`define RTCDSA_CTL_SRST     1
`define RTCDSA_CTL_STE      2
`define RTCDSA_CTL_BIN      3
`define RTCDSA_CTL_H12      4
`define RTCDSA_CTRL_RESET   5'h00

// ****************************************************************
// calendar constants
// ****************************************************************
`define RTCDSA_WEEK_LAST    3'h5
`define RTCDSA_WEEK_DAYS    8'h07

`endif

// ---- design/rtcdsa_rule_store.v ----
// holds the two rule words with byte-lane writes and their write-time hour mode
// assumes write data already converted to binary and masked by the caller
`timescale 1ns/1ps
`default_nettype none

`include "rtcdsa_defs.vh"

module rtcdsa_rule_store
(
	input  wire        clock,
	input  wire        clear,
	input  wire        wr_spring,
	input  wire        wr_autumn,
	input  wire [3:0]  strb,
	input  wire [31:0] wdata,
	input  wire        twelve_in,
	output reg  [31:0] spring_rule,
	output reg  [31:0] autumn_rule,
	output reg         spring_twelve,
	output reg         autumn_twelve
);

	integer i;

	// ****************************************************************
	// byte-lane storage
	// ****************************************************************
	always @(posedge clock)
	begin
		if (clear)
		begin
			spring_rule   <= `RTCDSA_RULE_RESET;
			autumn_rule   <= `RTCDSA_RULE_RESET;
			spring_twelve <= 1'b0;
			autumn_twelve <= 1'b0;
		end
		else
		begin
			for (i = 0; i < 4; i = i + 1)
			begin
				if (wr_spring && strb[i])
					spring_rule[i*8 +: 8] <= wdata[i*8 +: 8];
				if (wr_autumn && strb[i])
					autumn_rule[i*8 +: 8] <= wdata[i*8 +: 8];
			end
			// hour mode is latched with the hour byte
			if (wr_spring && strb[3])
				spring_twelve <= twelve_in;
			if (wr_autumn && strb[3])
				autumn_twelve <= twelve_in;
		end
	end

endmodule

`default_nettype wire

// ---- verif/rtcdsa_top_sva.sv ----
// port assertions for the summer-time adjust block
// assumes a bind onto rtcdsa_top and a single clock domain
`timescale 1ns/1ps
`default_nettype none

module rtcdsa_top_sva
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        hour_carry,
	input wire logic        hour_advance,
	input wire logic        hour_inhibit,
	input wire logic        block_enable,
	input wire logic        summer_time_enable
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_refused_no_data: assert property (pslverr |-> prdata == 32'h0)
		else $error("data on refused access");
	a_reserved_read_zero: assert property (pready && !pwrite && (paddr == 8'h18 ||
		paddr == 8'h1c) |-> (prdata & 32'h00f8_f800) == 32'h0)
		else $error("reserved rule bits set");
	a_advance_one_pulse: assert property (hour_advance |=> !hour_advance)
		else $error("advance longer than a cycle");
	a_advance_gated: assert property (hour_advance |->
		$past(block_enable && summer_time_enable))
		else $error("advance while not running");
	a_inhibit_gated: assert property ($rose(hour_inhibit) |->
		$past(block_enable && summer_time_enable))
		else $error("inhibit while not running");
	a_inhibit_released: assert property (hour_inhibit && hour_carry |=> !hour_inhibit)
		else $error("inhibit kept past carry");

	cover property (hour_advance);
	cover property ($rose(hour_inhibit));
	cover property (hour_inhibit && hour_carry);
	cover property (pslverr);
endmodule

bind rtcdsa_top rtcdsa_top_sva u_rtcdsa_top_sva(.clock(clock), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .hour_carry(hour_carry),
	.hour_advance(hour_advance), .hour_inhibit(hour_inhibit),
	.block_enable(block_enable), .summer_time_enable(summer_time_enable));

`default_nettype wire

// ---- verif/rtcdsa_top_tb.sv ----
// self-checking bench for the summer-time adjust block
// assumes the apb slave answers with no wait states and counters share the clock
`timescale 1ns/1ps
`default_nettype none

`include "rtcdsa_defs.vh"

module rtcdsa_top_tb;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [7:0]  cur_hours = 8'h01;
	logic [7:0]  cur_weekday = 8'h03;
	logic [7:0]  cur_month = 8'h03;
	logic [7:0]  cur_day = 8'h0a;
	logic [7:0]  cur_month_days = 8'h1f;
	logic        hour_carry = 1'b0;
	wire  [31:0] prdata;
	wire         pready, pslverr, hour_advance, hour_inhibit;
	wire         block_enable, summer_time_enable, binary_format_select, twelve_hour_mode;
	int          err_total = 0;
	int          checks = 0;
	int          seed = 80;
	logic [31:0] rd;
	logic        er;

	always #50 clock = ~clock;

	rtcdsa_top u_rtcdsa_top(.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cur_hours(cur_hours), .cur_weekday(cur_weekday), .cur_month(cur_month),
		.cur_day(cur_day), .cur_month_days(cur_month_days), .hour_carry(hour_carry),
		.hour_advance(hour_advance), .hour_inhibit(hour_inhibit),
		.block_enable(block_enable), .summer_time_enable(summer_time_enable),
		.binary_format_select(binary_format_select), .twelve_hour_mode(twelve_hour_mode));

	function automatic logic [7:0] bcd(input logic [7:0] v);
		return v[7:4] * 8'h0a + v[3:0];
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			err_total++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, e});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	initial
	begin
		logic [31:0] w;
		logic [31:0] d;
		logic [7:0]  a;
		tick(10);
		reset_n <= 1'b1;
		rdchk(8'h18, 32'h0, 1'b0);
		rdchk(8'h1c, 32'h0, 1'b0);
		rdchk(8'h24, 32'h0, 1'b1);
		apb(1'b1, 8'h20, 32'h08, 4'h1);
		tick(1);
		chk({31'h0, binary_format_select}, 32'h1);
		repeat (8)
		begin
			w = $random(seed);
			a = w[0] ? 8'h18 : 8'h1c;
			apb(1'b1, a, w, 4'hf);
			rdchk(a, w & `RTCDSA_RULE_MASK, 1'b0);
		end
		// byte lanes one at a time with the run stopped
		w = 32'h0;
		apb(1'b1, 8'h18, w, 4'hf);
		for (int i = 0; i < 4; i++)
		begin
			d = $random(seed);
			apb(1'b1, 8'h18, d, 4'(1 << i));
			w = w | (d & (32'hff << (8 * i)));
			rdchk(8'h18, w & `RTCDSA_RULE_MASK, 1'b0);
		end
		apb(1'b1, 8'h20, 32'h00, 4'h1);
		apb(1'b1, 8'h18, 32'h2301_0512, 4'hf);
		apb(1'b1, 8'h20, 32'h08, 4'h1);
		rdchk(8'h18, {bcd(8'h23), 16'h0105, bcd(8'h12)}, 1'b0);
		// both rules valid before the adjustment is ever enabled
		apb(1'b1, 8'h1c, 32'h0305_000a, 4'hf);
		apb(1'b1, 8'h18, 32'h0202_0303, 4'hf);
		for (int k = 1; k >= 0; k--)
		begin
			apb(1'b1, 8'h20, k ? 32'h0d : 32'h09, 4'h1);
			@(posedge clock);
			cur_hours <= 8'h02;
			tick(2);
			chk({31'h0, hour_advance}, k);
			cur_hours <= 8'h01;
		end
		// meridiem only counts when the rule was written in twelve-hour mode
		apb(1'b1, 8'h20, 32'h18, 4'h1);
		tick(1);
		chk({31'h0, twelve_hour_mode}, 32'h1);
		apb(1'b1, 8'h18, 32'h8202_0303, 4'hf);
		apb(1'b1, 8'h20, 32'h1d, 4'h1);
		for (int k = 0; k < 2; k++)
		begin
			cur_hours <= k ? 8'h82 : 8'h02;
			tick(2);
			chk({31'h0, hour_advance}, k);
			cur_hours <= 8'h01;
			tick(2);
		end
		apb(1'b1, 8'h20, 32'h08, 4'h1);
		apb(1'b1, 8'h1c, 32'h0305_000a, 4'hf);
		cur_weekday <= 8'h00;
		cur_month <= 8'h0a;
		cur_day <= 8'h1d;
		apb(1'b1, 8'h20, 32'h0d, 4'h1);
		@(posedge clock);
		cur_hours <= 8'h03;
		tick(2);
		chk({31'h0, hour_inhibit}, 32'h1);
		hour_carry <= 1'b1;
		@(posedge clock);
		hour_carry <= 1'b0;
		tick(1);
		chk({31'h0, hour_inhibit}, 32'h0);
		tick(3);
		chk({31'h0, hour_inhibit}, 32'h0);
		// status: spent state, last week, enable, summer enable, binary
		rdchk(8'h20, 32'h0000_220d, 1'b0);
		cur_hours <= 8'h04;
		tick(2);
		cur_hours <= 8'h03;
		tick(2);
		chk({31'h0, hour_inhibit}, 32'h1);
		apb(1'b1, 8'h20, 32'h02, 4'h1);
		rdchk(8'h1c, 32'h0, 1'b0);
		chk({31'h0, block_enable}, 32'h0);
		chk({30'h0, binary_format_select, twelve_hour_mode}, 32'h0);
		report_and_stop();
	end
endmodule

`default_nettype wire
